// ==== blit_raster_state_regs.sv ====
// Overview of operation
// - clip-enable bit one enables destination clipping, zero disables it
// - source transparency only acts when the source operand is monochrome
// - source transparency clear: zero source bits use source background
// - source transparency set: pixels with zero source bit not written
// - pattern transparency only acts when the pattern is monochrome
// - pattern transparency clear: zero pattern bits use pattern background
// - pattern transparency set: pixels with zero pattern bit not written unless solid pattern set
// - depth code 00 is 8 bit, 01 16 bit, 10 24 bit, 11 reserved
// - eight-bit raster code picks one of 256 source/pattern/dest combos
// - after each line, signed pitch is added to the line start address
// - 13-bit height is a working line counter updated while running
// - 13-bit width holds bytes per line; pixels depend on depth
// - patterns are 8 by 8; mono pattern comes in with instruction
// - low six bits of the pattern address always read zero
// - colours use 32, 16 or 8 low bits according to depth
// - mono pattern expansion uses the pattern fg and bg registers
// - source background feeds zero source bits; solid fill uses pattern background
// - mono source expansion foreground comes from source fg register
// - writing the destination address register starts the transfer
// - solid pattern set forces background operand for mono patterns only
`timescale 1ns/1ps
`default_nettype none
`include "blit_cfg.svh"

module blit_raster_state_regs #(
    parameter int ADDR_W = `BLIT_ADDR_W
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    // register port
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // per-pixel operand stream
    input wire logic PIX_VALID_I,
    input wire logic PIX_SRC_BIT_I,
    input wire logic [31:0] PIX_SRC_COLOR_I,
    input wire logic [31:0] PIX_PAT_COLOR_I,
    input wire logic [31:0] PIX_DST_I,
    // destination write
    output logic MEM_WR_O,
    output logic [3:0] MEM_BE_O,
    output logic [28:0] MEM_ADDR_O,
    output logic [31:0] MEM_WDATA_O,
    output logic PAT_FETCH_O,
    output logic CLIP_EN_O,
    output logic BUSY_O
);
    import blit_pkg::*;

    // ==================================================================
    // state registers
    blit_pkg::blit_word_t raster_op_control_reg;
    // height field doubles as the live line counter
    blit_pkg::blit_word_t dest_size_reg;
    blit_pkg::blit_word_t pattern_address_reg;
    blit_pkg::blit_word_t pattern_bg_reg;
    blit_pkg::blit_word_t pattern_fg_reg;
    blit_pkg::blit_word_t source_bg_reg;
    blit_pkg::blit_word_t source_fg_reg;
    blit_pkg::blit_word_t destination_address_reg;
    logic [1:0] operand_mono;
    logic [63:0] mono_pattern;
    blit_state_e state;
    logic [12:0] byte_left;
    logic [28:0] line_start;
    logic [5:0] pat_index;

    // ==================================================================
    // helper functions
    // colour trimmed to the active depth
    // 24-bit depth keeps the whole word for 32-bit colour registers
    function automatic logic [31:0] trim_color(input logic [31:0] c,
                                               input logic [1:0] d);
        logic [31:0] r;
        r = 32'h00000000;
        case (d)
            2'h0: r = {24'h000000, c[7:0]};
            2'h1: r = {16'h0000, c[15:0]};
            default: r = c;
        endcase
        return r;
    endfunction

    // byte enables for one pixel at the depth
    function automatic logic [3:0] depth_be(input logic [1:0] d);
        logic [3:0] r;
        r = 4'h0;
        case (d)
            2'h0: r = 4'h1;
            2'h1: r = 4'h3;
            2'h2: r = 4'h7;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // bytes per pixel at the depth
    function automatic logic [12:0] depth_bytes(input logic [1:0] d);
        logic [12:0] r;
        r = 13'h0001;
        case (d)
            2'h1: r = 13'h0002;
            2'h2: r = 13'h0003;
            default: r = 13'h0001;
        endcase
        return r;
    endfunction

    // ==================================================================
    // field decode
    wire logic solid_pat = raster_op_control_reg[`BLIT_BIT_SOLID];
    wire logic clip_en = raster_op_control_reg[`BLIT_BIT_CLIP];
    wire logic src_trans = raster_op_control_reg[`BLIT_BIT_SRC_TRANS];
    wire logic pat_trans = raster_op_control_reg[`BLIT_BIT_PAT_TRANS];
    wire logic [1:0] depth =
        raster_op_control_reg[`BLIT_DEPTH_HI:`BLIT_DEPTH_LO];
    wire logic [7:0] rop_code =
        raster_op_control_reg[`BLIT_ROP_HI:`BLIT_ROP_LO];
    // pitch is signed; it is sign-extended where it is added
    wire logic [15:0] dest_pitch =
        raster_op_control_reg[`BLIT_PITCH_HI:`BLIT_PITCH_LO];
    wire logic [12:0] dest_height =
        dest_size_reg[`BLIT_HEIGHT_HI:`BLIT_HEIGHT_LO];
    wire logic [12:0] dest_width =
        dest_size_reg[`BLIT_WIDTH_HI:`BLIT_WIDTH_LO];
    wire logic src_mono = operand_mono[`BLIT_BIT_SRC_MONO];
    wire logic pat_mono = operand_mono[`BLIT_BIT_PAT_MONO];

    // ==================================================================
    // bus decode
    wire logic wr_rop = REG_WR_I && REG_ADDR_I == `BLIT_OFF_ROP_CTRL;
    wire logic wr_size = REG_WR_I && REG_ADDR_I == `BLIT_OFF_DEST_SIZE;
    wire logic wr_pata = REG_WR_I && REG_ADDR_I == `BLIT_OFF_PAT_ADDR;
    wire logic wr_patbg = REG_WR_I && REG_ADDR_I == `BLIT_OFF_PAT_BG;
    wire logic wr_patfg = REG_WR_I && REG_ADDR_I == `BLIT_OFF_PAT_FG;
    wire logic wr_srcbg = REG_WR_I && REG_ADDR_I == `BLIT_OFF_SRC_BG;
    wire logic wr_srcfg = REG_WR_I && REG_ADDR_I == `BLIT_OFF_SRC_FG;
    wire logic wr_oper = REG_WR_I && REG_ADDR_I == `BLIT_OFF_OPERAND;
    wire logic wr_mlo = REG_WR_I && REG_ADDR_I == `BLIT_OFF_MONO_PAT_LO;
    wire logic wr_mhi = REG_WR_I && REG_ADDR_I == `BLIT_OFF_MONO_PAT_HI;
    // destination address write starts a transfer only when idle
    wire logic wr_dest = REG_WR_I && REG_ADDR_I == `BLIT_OFF_DEST_ADDR;
    wire logic busy = state != BLIT_IDLE;

    // read mux; unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (REG_ADDR_I)
            `BLIT_OFF_DEST_ADDR: rd_mux = destination_address_reg;
            `BLIT_OFF_ROP_CTRL: rd_mux = raster_op_control_reg;
            `BLIT_OFF_DEST_SIZE: rd_mux = dest_size_reg;
            `BLIT_OFF_PAT_ADDR:
                rd_mux = pattern_address_reg & `BLIT_PAT_ADDR_MASK;
            `BLIT_OFF_PAT_BG: rd_mux = pattern_bg_reg;
            `BLIT_OFF_PAT_FG: rd_mux = pattern_fg_reg;
            `BLIT_OFF_SRC_BG: rd_mux = source_bg_reg;
            `BLIT_OFF_SRC_FG: rd_mux = source_fg_reg;
            `BLIT_OFF_OPERAND: rd_mux = {30'h00000000, operand_mono};
            // status lets software poll for the end of a transfer
            `BLIT_OFF_STATUS: rd_mux = {31'h00000000, busy};
            `BLIT_OFF_MONO_PAT_LO: rd_mux = mono_pattern[31:0];
            `BLIT_OFF_MONO_PAT_HI: rd_mux = mono_pattern[63:32];
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ==================================================================
    // pixel datapath
    // pattern rows step per line, columns per pixel
    // 8x8 mono pattern bit for this pixel
    wire logic pat_bit = mono_pattern[pat_index];
    // source expansion, fg, bg when zero
    // pattern background, not source background, is the solid fill colour
    wire logic [31:0] src_op = !src_mono ? PIX_SRC_COLOR_I :
        (PIX_SRC_BIT_I ? source_fg_reg : source_bg_reg);
    wire logic [31:0] pat_op = !pat_mono ? PIX_PAT_COLOR_I :
        (solid_pat ? pattern_bg_reg :
        (pat_bit ? pattern_fg_reg : pattern_bg_reg));
    wire logic [31:0] s_t = trim_color(src_op, depth);
    wire logic [31:0] p_t = trim_color(pat_op, depth);
    wire logic [31:0] d_t = trim_color(PIX_DST_I, depth);

    // raster operation, bit index {pattern, source, destination}
    logic [31:0] rop_out;
    always_comb begin
        rop_out = 32'h00000000;
        for (int i = 0; i < 32; i++) begin
            rop_out[i] = rop_code[{p_t[i], s_t[i], d_t[i]}];
        end
    end

    // write data cut to the pixel bytes; top byte idle at 24 bit
    wire logic [31:0] rop_trim = (depth == 2'h2) ?
        {8'h00, rop_out[23:0]} : trim_color(rop_out, depth);

    // source suppress only for mono zero bits
    wire logic src_skip = src_mono && src_trans && !PIX_SRC_BIT_I;
    // a solid pattern never makes a pixel transparent
    // pattern suppress only for mono zero bits
    wire logic pat_skip = pat_mono && pat_trans && !solid_pat && !pat_bit;
    wire logic [3:0] pix_be = (src_skip || pat_skip) ? 4'h0 : depth_be(depth);
    wire logic [12:0] pix_bytes = depth_bytes(depth);
    wire logic last_pix = byte_left <= pix_bytes;
    wire logic pix_take = state == BLIT_PIXEL && PIX_VALID_I;
    wire logic [28:0] next_line_start =
        line_start + {{13{dest_pitch[15]}}, dest_pitch};

    // ==================================================================
    // register writes
    // colours and modes may change at any time; next pixel uses them
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            raster_op_control_reg <= `BLIT_RESET_WORD;
            pattern_address_reg <= `BLIT_RESET_WORD;
            pattern_bg_reg <= `BLIT_RESET_WORD;
            pattern_fg_reg <= `BLIT_RESET_WORD;
            source_bg_reg <= `BLIT_RESET_WORD;
            source_fg_reg <= `BLIT_RESET_WORD;
            operand_mono <= 2'h0;
            mono_pattern <= 64'h0000000000000000;
        end else begin
            if (wr_rop) raster_op_control_reg <= REG_WDATA_I;
            if (wr_pata) pattern_address_reg <= REG_WDATA_I;
            if (wr_patbg) pattern_bg_reg <= REG_WDATA_I;
            if (wr_patfg) pattern_fg_reg <= REG_WDATA_I;
            if (wr_srcbg) source_bg_reg <= REG_WDATA_I;
            if (wr_srcfg) source_fg_reg <= REG_WDATA_I;
            if (wr_oper) operand_mono <= REG_WDATA_I[1:0];
            if (wr_mlo) mono_pattern[31:0] <= REG_WDATA_I;
            if (wr_mhi) mono_pattern[63:32] <= REG_WDATA_I;
        end
    end

    // ==================================================================
    // transfer sequencer
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            state <= BLIT_IDLE;
            dest_size_reg <= `BLIT_RESET_WORD;
            destination_address_reg <= `BLIT_RESET_WORD;
            byte_left <= 13'h0000;
            line_start <= 29'h00000000;
            pat_index <= 6'h00;
        end else begin
            case (state)
                BLIT_IDLE: begin
                    if (wr_size) begin
                        dest_size_reg <= REG_WDATA_I & `BLIT_SIZE_MASK;
                    end
                    if (wr_dest) begin
                        destination_address_reg <=
                            REG_WDATA_I & `BLIT_ADDR_MASK;
                        line_start <= REG_WDATA_I[28:0];
                        byte_left <= dest_width;
                        pat_index <= 6'h00;
                        // zero width or height is not started; the sequencer stays idle
                        // reserved depth runs but writes nothing
                        if (dest_height != 13'h0000 &&
                            dest_width != 13'h0000) begin
                            state <= BLIT_PIXEL;
                        end
                    end
                end
                BLIT_PIXEL: begin
                    if (pix_take) begin
                        pat_index[2:0] <= pat_index[2:0] + 3'h1;
                        destination_address_reg[28:0] <=
                            destination_address_reg[28:0] +
                            {16'h0000, pix_bytes};
                        byte_left <= byte_left - pix_bytes;
                        if (last_pix) begin
                            state <= BLIT_LINE_END;
                        end
                    end
                end
                BLIT_LINE_END: begin
                    // idle cycle per line keeps the pitch add apart
                    // address reloads from line start, not pixel walk
                    // next line from pitch
                    line_start <= next_line_start;
                    destination_address_reg[28:0] <= next_line_start;
                    byte_left <= dest_width;
                    pat_index <= {pat_index[5:3] + 3'h1, 3'h0};
                    dest_size_reg[`BLIT_HEIGHT_HI:`BLIT_HEIGHT_LO] <=
                        dest_height - 13'h0001;
                    if (dest_height == 13'h0001) begin
                        state <= BLIT_IDLE;
                    end else begin
                        state <= BLIT_PIXEL;
                    end
                end
                default: state <= BLIT_IDLE;
            endcase
        end
    end

    // ==================================================================
    // registered outputs
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            REG_RDATA_O <= 32'h00000000;
            MEM_WR_O <= 1'b0;
            MEM_BE_O <= 4'h0;
            MEM_ADDR_O <= 29'h00000000;
            MEM_WDATA_O <= 32'h00000000;
            PAT_FETCH_O <= 1'b0;
            CLIP_EN_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            // read data stand one cycle, then return to zero
            REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h00000000;
            MEM_WR_O <= pix_take && pix_be != 4'h0;
            MEM_BE_O <= pix_take ? pix_be : 4'h0;
            // address of the pixel taken on this edge
            MEM_ADDR_O <= destination_address_reg[28:0];
            MEM_WDATA_O <= rop_trim;
            // mono patterns come with the command, colour ones are read
            // no pattern reads when mono; solid does not stop them
            PAT_FETCH_O <= busy && !pat_mono;
            // plain copy; the clipping itself happens downstream
            // clip enable
            CLIP_EN_O <= clip_en;
            BUSY_O <= busy;
        end
    end

endmodule

`default_nettype wire

// ==== blit_cfg.svh ====
`ifndef BLIT_CFG_SVH
`define BLIT_CFG_SVH

// register offsets, byte addresses on the plain register port
`define BLIT_ADDR_W 20
`define BLIT_OFF_DEST_ADDR 20'h40024
`define BLIT_OFF_ROP_CTRL 20'h40034
`define BLIT_OFF_DEST_SIZE 20'h40038
`define BLIT_OFF_PAT_ADDR 20'h4003C
`define BLIT_OFF_PAT_BG 20'h40040
`define BLIT_OFF_PAT_FG 20'h40044
`define BLIT_OFF_SRC_BG 20'h40048
`define BLIT_OFF_SRC_FG 20'h4004C
`define BLIT_OFF_OPERAND 20'h40050
`define BLIT_OFF_STATUS 20'h40054
`define BLIT_OFF_MONO_PAT_LO 20'h40058
`define BLIT_OFF_MONO_PAT_HI 20'h4005C

// control register fields
`define BLIT_BIT_SOLID 31
`define BLIT_BIT_CLIP 30
`define BLIT_BIT_SRC_TRANS 29
`define BLIT_BIT_PAT_TRANS 28
`define BLIT_DEPTH_HI 25
`define BLIT_DEPTH_LO 24
`define BLIT_ROP_HI 23
`define BLIT_ROP_LO 16
`define BLIT_PITCH_HI 15
`define BLIT_PITCH_LO 0

// size register fields
`define BLIT_HEIGHT_HI 28
`define BLIT_HEIGHT_LO 16
`define BLIT_WIDTH_HI 12
`define BLIT_WIDTH_LO 0

// operand select register fields
`define BLIT_BIT_SRC_MONO 0
`define BLIT_BIT_PAT_MONO 1

// address masks and reset values
`define BLIT_ADDR_MASK 32'h1FFFFFFF
`define BLIT_PAT_ADDR_MASK 32'h1FFFFFC0
`define BLIT_SIZE_MASK 32'h1FFF1FFF
`define BLIT_RESET_WORD 32'h00000000

`endif

// ==== blit_pkg.sv ====
`default_nettype none
package blit_pkg;

    typedef enum logic [1:0] {
        BLIT_DEPTH_8,
        BLIT_DEPTH_16,
        BLIT_DEPTH_24,
        BLIT_DEPTH_RSVD
    } blit_depth_e;

    typedef enum logic [1:0] {
        BLIT_IDLE,
        BLIT_PIXEL,
        BLIT_LINE_END
    } blit_state_e;

    typedef logic [31:0] blit_word_t;

endpackage
`default_nettype wire

// ==== brsr_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "blit_cfg.svh"
module brsr_asserts #(
    parameter int ADDR_W = 20
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic MEM_WR_O,
    input wire logic [3:0] MEM_BE_O,
    input wire logic [28:0] MEM_ADDR_O,
    input wire logic [31:0] MEM_WDATA_O,
    input wire logic PAT_FETCH_O,
    input wire logic CLIP_EN_O,
    input wire logic BUSY_O
);
    import blit_pkg::*;
    // ==================================================
    // shadow state
    logic [31:0] ctrl;
    logic [31:0] size;
    logic pat_mono;
    logic rd_pat;
    wire wr_ctrl = REG_WR_I && REG_ADDR_I == `BLIT_OFF_ROP_CTRL;
    wire [1:0] depth = ctrl[25:24];
    wire [2:0] bpp = {1'b0, depth} + 3'h1;
    wire [3:0] be = (depth == 2'h0) ? 4'h1 : (depth == 2'h1) ? 4'h3 : 4'h7;
    wire [31:0] mask = {8'h00, {8{be[2]}}, {8{be[1]}}, 8'hFF};
    // copies of the loaded registers
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ctrl <= 32'h0;
            size <= 32'h0;
            pat_mono <= 1'b0;
            rd_pat <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == `BLIT_OFF_DEST_SIZE && !BUSY_O)
                size <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == `BLIT_OFF_OPERAND)
                pat_mono <= REG_WDATA_I[`BLIT_BIT_PAT_MONO];
            rd_pat <= REG_RD_I && REG_ADDR_I == `BLIT_OFF_PAT_ADDR;
        end
    end
    // ==================================================
    // properties
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_ctrl_settle;
        wr_ctrl ##1 !wr_ctrl [*2];
    endsequence
    sequence s_start;
        REG_WR_I && REG_ADDR_I == `BLIT_OFF_DEST_ADDR && !BUSY_O &&
            size[28:16] != 13'h0 && size[12:0] != 13'h0 && depth != 2'h3;
    endsequence
    a_rdata_idle_zero: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 0)
        else $error("read data not zero outside read slot");
    a_pat_addr_low: assert property (rd_pat |-> REG_RDATA_O[5:0] == 6'h0)
        else $error("pattern address low bits not zero");
    a_clip_follows: assert property (s_ctrl_settle |-> CLIP_EN_O == ctrl[30])
        else $error("clip enable output differs from control bit");
    a_byte_enable_depth: assert property (MEM_WR_O |-> MEM_BE_O == be)
        else $error("byte enables do not match depth");
    a_wdata_trimmed: assert property (MEM_WR_O |-> (MEM_WDATA_O & ~mask) == 0)
        else $error("write data not trimmed to depth");
    a_addr_step: assert property (MEM_WR_O && $past(MEM_WR_O) |->
        MEM_ADDR_O == $past(MEM_ADDR_O) + 29'(bpp))
        else $error("pixel address step wrong");
    a_write_busy: assert property (MEM_WR_O |-> BUSY_O)
        else $error("destination write while idle");
    a_start_busy: assert property (s_start |-> ##2 BUSY_O)
        else $error("transfer did not start");
    a_fetch_colour: assert property (PAT_FETCH_O |-> BUSY_O && !pat_mono)
        else $error("pattern fetch with mono pattern or idle");
    a_fetch_rise: assert property ($rose(BUSY_O) && !pat_mono |-> PAT_FETCH_O)
        else $error("colour pattern not fetched");
endmodule
bind blit_raster_state_regs brsr_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .MEM_WR_O(MEM_WR_O), .MEM_BE_O(MEM_BE_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
    .PAT_FETCH_O(PAT_FETCH_O), .CLIP_EN_O(CLIP_EN_O), .BUSY_O(BUSY_O)
);
`default_nettype wire

// ==== brsr_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module brsr_mem_model (
    input wire logic clk_i,
    input wire logic wr_i,
    input wire logic [3:0] be_i,
    input wire logic [28:0] addr_i,
    input wire logic [31:0] data_i
);
    logic [7:0] bytes [int];
    // forget all stored bytes between transfers
    task automatic clear();
        bytes.delete();
    endtask
    always @(posedge clk_i) begin
        if (wr_i === 1'b1) begin
            for (int k = 0; k < 4; k++) begin
                if (be_i[k]) bytes[int'(addr_i) + k] = data_i[8*k +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb_blit_raster_state_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_blit_raster_state_regs;
    import blit_pkg::*;
    logic CLK_I = 0, RESET_I = 1, REG_WR_I = 0, REG_RD_I = 0;
    logic PIX_VALID_I = 0, PIX_SRC_BIT_I = 0;
    logic [19:0] REG_ADDR_I = 0;
    logic [31:0] REG_WDATA_I = 0, PIX_SRC_COLOR_I = 0;
    logic [31:0] PIX_PAT_COLOR_I = 0, PIX_DST_I = 0;
    wire logic [31:0] REG_RDATA_O, MEM_WDATA_O;
    wire logic MEM_WR_O, PAT_FETCH_O, CLIP_EN_O, BUSY_O;
    wire logic [3:0] MEM_BE_O;
    wire logic [28:0] MEM_ADDR_O;
    int error_cnt = 0, total_checks = 0, cycles = 0;
    // ==================================================
    // clock, design and memory
    initial forever #25 CLK_I = ~CLK_I;
    blit_raster_state_regs DUT (.CLK_I(CLK_I), .RESET_I(RESET_I),
        .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
        .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
        .PIX_VALID_I(PIX_VALID_I), .PIX_SRC_BIT_I(PIX_SRC_BIT_I),
        .PIX_SRC_COLOR_I(PIX_SRC_COLOR_I), .PIX_PAT_COLOR_I(PIX_PAT_COLOR_I),
        .PIX_DST_I(PIX_DST_I), .MEM_WR_O(MEM_WR_O), .MEM_BE_O(MEM_BE_O),
        .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
        .PAT_FETCH_O(PAT_FETCH_O), .CLIP_EN_O(CLIP_EN_O), .BUSY_O(BUSY_O));
    brsr_mem_model MEM (.clk_i(CLK_I), .wr_i(MEM_WR_O), .be_i(MEM_BE_O),
        .addr_i(MEM_ADDR_O), .data_i(MEM_WDATA_O));
    // ==================================================
    // comparison, verdict and bus tasks
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [19:0] ad, input logic [31:0] d);
        @(posedge CLK_I);
        REG_ADDR_I <= ad;
        REG_WDATA_I <= d;
        REG_WR_I <= 1'b1;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] ad, output logic [31:0] d);
        @(posedge CLK_I);
        REG_ADDR_I <= ad;
        REG_RD_I <= 1'b1;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        #1 d = REG_RDATA_O;
    endtask
    // bitwise raster operation, index is pattern, source, destination
    function automatic logic [31:0] rop_fn(logic [7:0] r, logic [31:0] p,
        logic [31:0] s, logic [31:0] d);
        for (int i = 0; i < 32; i++) rop_fn[i] = r[{p[i], s[i], d[i]}];
    endfunction
    // hang guard
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            results();
        end
    end
    // ==================================================
    // main sequence
    initial begin
        logic [31:0] v, res, msk, sbg, sfg, pbg, pfg, sv, pv;
        logic [7:0] raster_operation_code;
        logic sm, pm, sb, st_, pt, sol, mp, clip, supp;
        int dep, bpp, w, h, pit, st, n;
        v = $urandom(54);
        repeat (12) @(posedge CLK_I);
        RESET_I <= 1'b0;
        for (int a = 0; a < 15; a++) begin
            rd(20'h40024 + 20'(4 * a), v);
            check(v, 32'h0, "reset or unmapped read");
        end
        wr(20'h40070, 32'hFFFFFFFF);
        rd(20'h40070, v);
        check(v, 32'h0, "unmapped write");
        wr(`BLIT_OFF_PAT_ADDR, 32'hFFFFFFFF);
        rd(`BLIT_OFF_PAT_ADDR, v);
        check(v, 32'h1FFFFFC0, "pattern address");
        wr(`BLIT_OFF_DEST_SIZE, 32'hFFFFFFFF);
        rd(`BLIT_OFF_DEST_SIZE, v);
        check(v, 32'h1FFF1FFF, "size fields");
        for (int t = 0; t < 30; t++) begin
            dep = t % 4;
            bpp = (dep == 3) ? 1 : dep + 1;
            w = bpp * (1 + $urandom % 4);
            h = 1 + $urandom % 3;
            pit = w + $urandom % 8;
            if ($urandom % 2) pit = -pit;
            st = 32'h100000 + $urandom % 64;
            {sm, pm, sb, st_, pt, sol, mp, clip} = 8'($urandom);
            raster_operation_code = 8'($urandom);
            if (raster_operation_code == 8'hF0) sm = 1'b1;
            {pbg, pfg, sbg, sfg} = {$urandom, $urandom, $urandom, $urandom};
            wr(`BLIT_OFF_PAT_BG, pbg);
            wr(`BLIT_OFF_PAT_FG, pfg);
            wr(`BLIT_OFF_PAT_ADDR, 32'h40 << dep);
            wr(`BLIT_OFF_SRC_BG, sbg);
            wr(`BLIT_OFF_SRC_FG, sfg);
            wr(`BLIT_OFF_OPERAND, {30'h0, pm, sm});
            wr(`BLIT_OFF_MONO_PAT_LO, {32{mp}});
            wr(`BLIT_OFF_MONO_PAT_HI, {32{mp}});
            wr(`BLIT_OFF_DEST_SIZE, {3'h0, 13'(h), 3'h0, 13'(w)});
            wr(`BLIT_OFF_ROP_CTRL,
                {sol, clip, st_, pt, 2'h0, 2'(dep), raster_operation_code, 16'(pit)});
            PIX_SRC_BIT_I <= sb;
            PIX_SRC_COLOR_I <= $urandom;
            PIX_PAT_COLOR_I <= $urandom;
            PIX_DST_I <= $urandom;
            // operands stand for every pixel of the w by h area
            PIX_VALID_I <= 1'b1;
            MEM.clear();
            wr(`BLIT_OFF_DEST_ADDR, 32'(st));
            n = 0;
            while (BUSY_O !== 1'b1 && n < 10) begin
                @(posedge CLK_I);
                n++;
            end
            while (BUSY_O !== 1'b0 && n < 2000) begin
                @(posedge CLK_I);
                n++;
            end
            PIX_VALID_I <= 1'b0;
            repeat (2) @(posedge CLK_I);
            check(BUSY_O, 1'b0, "transfer finished");
            // expected pixel from the operand selection
            msk = (dep == 0) ? 32'hFF : (dep == 1) ? 32'hFFFF : 32'hFFFFFF;
            sv = sm ? (sb ? sfg : sbg) : PIX_SRC_COLOR_I;
            pv = pm ? ((sol || !mp) ? pbg : pfg) : PIX_PAT_COLOR_I;
            res = rop_fn(raster_operation_code, pv, sv, PIX_DST_I) & msk;
            supp = (sm && !sb && st_) || (pm && !sol && !mp && pt) ||
                dep == 3;
            check(CLIP_EN_O, clip, "clip enable");
            check(MEM.bytes.num(), supp ? 0 : w * h, "bytes");
            for (int l = 0; l < h && !supp; l++) begin
                for (int x = 0; x < w; x++) begin
                    n = st + l * pit + x;
                    check(MEM.bytes[n], res[8*(x%bpp) +: 8], "pixel");
                end
            end
            rd(`BLIT_OFF_DEST_SIZE, v);
            check(v[28:16], 32'h0, "height count");
            rd(`BLIT_OFF_PAT_ADDR, v);
            check(v, 32'h40 << dep, "aligned pattern address");
        end
        results();
    end
endmodule
`default_nettype wire
